// ===== abr_far_model.sv
// far-side model: clock and data sources of codec, transceivers and header
`timescale 1ns/1ps
module abr_far_model (
  input wire logic clock,
  input wire logic arst_n,
  output logic [14:0] far_src
);
  logic [15:0] lfsr_reg;
  // each source sits on its own tap, so picking the wrong one shows within a few cycles
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) lfsr_reg <= 16'hace1;
    else lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end
  assign far_src = lfsr_reg[14:0];
endmodule : abr_far_model

// ===== abr_pkg.sv
// package: constants and types for the audio board clock/data router
package abr_pkg;

  // ---------------------------------------------------------------
  // configuration word layout (switch bank and pc port share it)
  // ---------------------------------------------------------------
  localparam int ABR_CFG_W = 10;
  localparam int ABR_MS_LSB = 0;
  localparam int ABR_MCLK_LSB = 2;
  localparam int ABR_SERIAL_DATA_INPUT_POS = 4;
  localparam int ABR_COAX_POS = 5;
  localparam int ABR_FMT_POS = 6;
  localparam int ABR_RATIO_POS = 7;
  localparam int ABR_SPEED_LSB = 8;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] ABR_MS_CODEC = 2'h0;
  localparam logic [1:0] ABR_MS_RX = 2'h1;
  localparam logic [1:0] ABR_MS_TX = 2'h2;
  localparam logic [1:0] ABR_MS_HDR = 2'h3;
  localparam logic [1:0] ABR_MC_RX = 2'h0;
  localparam logic [1:0] ABR_MC_CODEC = 2'h1;
  localparam logic [1:0] ABR_SPEED_SS_NODEEMPH = 2'h1;
  // defaults: codec master, rx mclk, rx serial_data_input, optical, lj, 256fs, single-speed no de-emph
  localparam logic [9:0] ABR_CFG_RESET = 10'h100;

  typedef enum logic [1:0] {ABR_SRC_CODEC, ABR_SRC_RX, ABR_SRC_TX, ABR_SRC_HDR} abr_src_t;

endpackage : abr_pkg

// ===== abr_router.sv
// audio board clock and data router: selection latch and signal steering
// Behaviour
// - switch bank settings take effect only after the reset push-button is pressed
// - attached pc cable enables pc control and ignores the switch bank
// - pc port carries codec spi/i2c control and board configuration
// - pcm header mclk, bit clock, frame clock direction follows selection
// - pcm header gets buffered codec output; header input may feed codec input
// - transmitter data comes from tx data header when pc config selects it
// - rx data header always copies receiver serial data output
// - external control header drives control signals outward by default
// - fitted direction jumper makes control header an input feeding the codec
// - serial clock master: 00 codec, 01 rx, 10 tx, 11 header
// - mclk source: 00 rx, 01 codec, 10/11 header
// - codec serial input: 0 receiver, 1 header
// - spdif input: 0 optical, 1 coaxial
// - format: 0 left-justified 24-bit, 1 i2s 24-bit
// - mclk ratio: 0 256 fs, 1 128 fs
// - speed: 00 ss de-emph, 01 ss, 10 double, 11 quad
// - spdif select drives receiver input multiplexer
// - receiver data flagged invalid when mclk not from receiver
`timescale 1ns/1ps
module abr_router
  import abr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reset_pushbutton,
  input wire logic pc_port_connector,
  input wire logic [9:0] config_switch_bank,
  input wire logic pc_cfg_valid,
  input wire logic [9:0] pc_cfg_data,
  input wire logic pc_spi_cs_n,
  input wire logic pc_spi_clk,
  input wire logic pc_spi_mosi,
  input wire logic control_dir_jumper,
  input wire logic ext_ctl_cs_n_in,
  input wire logic ext_ctl_clk_in,
  input wire logic ext_ctl_mosi_in,
  output logic ext_ctl_cs_n_out,
  output logic ext_ctl_clk_out,
  output logic ext_ctl_mosi_out,
  output logic ext_ctl_oe_n,
  output logic codec_ctl_cs_n,
  output logic codec_ctl_clk,
  output logic codec_ctl_mosi,
  input wire logic codec_mclk,
  input wire logic rx_mclk,
  input wire logic hdr_mclk_in,
  output logic hdr_mclk_out,
  output logic hdr_mclk_oe_n,
  output logic mclk_to_board,
  input wire logic codec_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic tx_bit_clock,
  input wire logic hdr_bit_clock_in,
  output logic hdr_bit_clock_out,
  output logic hdr_bit_clock_oe_n,
  output logic bit_clock_to_board,
  input wire logic codec_frame_clock,
  input wire logic rx_frame_clock,
  input wire logic tx_frame_clock,
  input wire logic hdr_frame_clock_in,
  output logic hdr_frame_clock_out,
  output logic hdr_frame_clock_oe_n,
  output logic frame_clock_to_board,
  input wire logic codec_serial_data_output,
  input wire logic rx_serial_data_output,
  input wire logic hdr_serial_data_in,
  input wire logic tx_data_header,
  output logic pcm_header_serial_data_output,
  output logic rx_data_header,
  output logic codec_serial_data_input,
  output logic tx_serial_data_input,
  output logic [1:0] serial_master_sel,
  output logic [1:0] mclk_src_sel,
  output logic serial_data_input_src_sel,
  output logic rx_coax_sel,
  output logic format_sel,
  output logic mclk_ratio_128,
  output logic [1:0] codec_speed_mode,
  output logic rx_data_valid,
  output logic pc_control_active
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // data and clock paths are combinational steering; only the
  // configuration inputs cross into the clocked latch
  logic [13:0] sync_q;
  logic [9:0] pc_dat_s;
  logic btn_s, pc_att_s, pc_val_s;
  logic [9:0] sw_s;
  logic jmp_s;

  abr_sync #(.WIDTH(14)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d({control_dir_jumper, reset_pushbutton, pc_port_connector, pc_cfg_valid, config_switch_bank}),
    .q(sync_q)
  );
  assign sw_s = sync_q[9:0];
  assign pc_val_s = sync_q[10];
  assign pc_att_s = sync_q[11];
  assign btn_s = sync_q[12];
  assign jmp_s = sync_q[13];

  // the pc word is synchronised beside its strobe; it is held stable while
  // the strobe is high, so no bit can be caught mid-change at the load edge
  abr_sync #(.WIDTH(10)) u_sync_pc (
    .clock(clock),
    .arst_n(arst_n),
    .d(pc_cfg_data),
    .q(pc_dat_s)
  );

  // ---------------------------------------------------------------
  // configuration latch
  // ---------------------------------------------------------------
  logic [9:0] cfg_reg;
  logic pc_mode_reg;
  logic pc_val_d_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_val_d_reg <= 1'b0;
    end else begin
      pc_val_d_reg <= pc_val_s;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_mode_reg <= 1'b0;
    end else begin
      pc_mode_reg <= pc_att_s;
    end
  end

  // switch values are sampled only while the button is held, so a
  // change of switches alone never disturbs running routing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= ABR_CFG_RESET;
    end else if (pc_att_s) begin
      if (pc_val_s && !pc_val_d_reg) begin
        cfg_reg <= pc_dat_s;
      end
    end else if (btn_s) begin
      cfg_reg <= sw_s;
    end
  end

  assign pc_control_active = pc_mode_reg;

  // ---------------------------------------------------------------
  // decoded selections
  // ---------------------------------------------------------------
  function automatic abr_src_t mclk_src(input logic [1:0] sel);
    case (sel)
      ABR_MC_RX: mclk_src = ABR_SRC_RX;
      ABR_MC_CODEC: mclk_src = ABR_SRC_CODEC;
      default: mclk_src = ABR_SRC_HDR;
    endcase
  endfunction : mclk_src

  function automatic abr_src_t sclk_src(input logic [1:0] sel);
    case (sel)
      ABR_MS_CODEC: sclk_src = ABR_SRC_CODEC;
      ABR_MS_RX: sclk_src = ABR_SRC_RX;
      ABR_MS_TX: sclk_src = ABR_SRC_TX;
      default: sclk_src = ABR_SRC_HDR;
    endcase
  endfunction : sclk_src

  abr_src_t mc_src, sc_src;
  assign serial_master_sel = cfg_reg[ABR_MS_LSB +: 2];
  assign mclk_src_sel = cfg_reg[ABR_MCLK_LSB +: 2];
  assign serial_data_input_src_sel = cfg_reg[ABR_SERIAL_DATA_INPUT_POS];
  assign rx_coax_sel = cfg_reg[ABR_COAX_POS];
  assign format_sel = cfg_reg[ABR_FMT_POS];
  assign mclk_ratio_128 = cfg_reg[ABR_RATIO_POS];
  assign codec_speed_mode = cfg_reg[ABR_SPEED_LSB +: 2];
  assign mc_src = mclk_src(mclk_src_sel);
  assign sc_src = sclk_src(serial_master_sel);
  assign rx_data_valid = (mc_src == ABR_SRC_RX);

  // ---------------------------------------------------------------
  // clock steering
  // ---------------------------------------------------------------
  always_comb begin
    case (mc_src)
      ABR_SRC_RX: mclk_to_board = rx_mclk;
      ABR_SRC_CODEC: mclk_to_board = codec_mclk;
      default: mclk_to_board = hdr_mclk_in;
    endcase
  end

  always_comb begin
    case (sc_src)
      ABR_SRC_CODEC: begin
        bit_clock_to_board = codec_bit_clock;
        frame_clock_to_board = codec_frame_clock;
      end
      ABR_SRC_RX: begin
        bit_clock_to_board = rx_bit_clock;
        frame_clock_to_board = rx_frame_clock;
      end
      ABR_SRC_TX: begin
        bit_clock_to_board = tx_bit_clock;
        frame_clock_to_board = tx_frame_clock;
      end
      default: begin
        bit_clock_to_board = hdr_bit_clock_in;
        frame_clock_to_board = hdr_frame_clock_in;
      end
    endcase
  end

  // header buffers never fight an external master
  assign hdr_mclk_out = mclk_to_board;
  assign hdr_mclk_oe_n = (mc_src == ABR_SRC_HDR);
  assign hdr_bit_clock_out = bit_clock_to_board;
  assign hdr_bit_clock_oe_n = (sc_src == ABR_SRC_HDR);
  assign hdr_frame_clock_out = frame_clock_to_board;
  assign hdr_frame_clock_oe_n = (sc_src == ABR_SRC_HDR);

  // ---------------------------------------------------------------
  // data steering
  // ---------------------------------------------------------------
  // tx data source reuses the serial_data_input select bit: no separate field exists
  assign pcm_header_serial_data_output = codec_serial_data_output;
  assign rx_data_header = rx_serial_data_output;
  assign codec_serial_data_input = serial_data_input_src_sel ? hdr_serial_data_in
                                                : rx_serial_data_output;
  assign tx_serial_data_input = (pc_mode_reg && serial_data_input_src_sel) ? tx_data_header
                                                              : codec_serial_data_output;

  // ---------------------------------------------------------------
  // control port steering
  // ---------------------------------------------------------------
  assign ext_ctl_oe_n = jmp_s;
  assign ext_ctl_cs_n_out = pc_spi_cs_n;
  assign ext_ctl_clk_out = pc_spi_clk;
  assign ext_ctl_mosi_out = pc_spi_mosi;
  assign codec_ctl_cs_n = jmp_s ? ext_ctl_cs_n_in : pc_spi_cs_n;
  assign codec_ctl_clk = jmp_s ? ext_ctl_clk_in : pc_spi_clk;
  assign codec_ctl_mosi = jmp_s ? ext_ctl_mosi_in : pc_spi_mosi;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_switch_hold: assert property (@(posedge clock) disable iff (!arst_n)
    (!pc_att_s && !btn_s) |=> $stable(cfg_reg))
    else $error("cfg changed without button");
  a_pc_ignores_sw: assert property (@(posedge clock) disable iff (!arst_n)
    (pc_att_s && !(pc_val_s && !pc_val_d_reg)) |=> $stable(cfg_reg))
    else $error("cfg changed in pc mode");
  a_pc_load: assert property (@(posedge clock) disable iff (!arst_n)
    (pc_att_s && pc_val_s && !pc_val_d_reg) |=> cfg_reg == $past(pc_cfg_data, 3))
    else $error("pc config not loaded");
  a_hdr_mclk_dir: assert property (@(posedge clock) disable iff (!arst_n)
    hdr_mclk_oe_n == cfg_reg[ABR_MCLK_LSB+1])
    else $error("mclk header direction");
  a_hdr_sclk_dir: assert property (@(posedge clock) disable iff (!arst_n)
    hdr_bit_clock_oe_n == (serial_master_sel == ABR_MS_HDR))
    else $error("sclk direction");
  a_rx_valid: assert property (@(posedge clock) disable iff (!arst_n)
    rx_data_valid == (mclk_src_sel == ABR_MC_RX))
    else $error("rx valid flag");
  a_ctl_dir: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(control_dir_jumper) |-> ##2 ext_ctl_oe_n)
    else $error("ctl header direction");
  a_serial_data_input_route: assert property (@(posedge clock) disable iff (!arst_n)
    !serial_data_input_src_sel |-> codec_serial_data_input == rx_serial_data_output)
    else $error("serial_data_input route");
  a_frame_dir: assert property (@(posedge clock) disable iff (!arst_n)
    hdr_frame_clock_oe_n == (serial_master_sel == ABR_MS_HDR))
    else $error("frame clock direction");
  a_serial_data_input_hdr: assert property (@(posedge clock) disable iff (!arst_n)
    serial_data_input_src_sel |-> codec_serial_data_input == hdr_serial_data_in)
    else $error("serial_data_input header route");
  a_tx_source: assert property (@(posedge clock) disable iff (!arst_n)
    (pc_control_active && serial_data_input_src_sel) |-> tx_serial_data_input == tx_data_header)
    else $error("tx data source");
  a_rx_copy: assert property (@(posedge clock) disable iff (!arst_n)
    rx_data_header == rx_serial_data_output)
    else $error("rx data header copy");
  a_serial_data_output_copy: assert property (@(posedge clock) disable iff (!arst_n)
    pcm_header_serial_data_output == codec_serial_data_output)
    else $error("header serial_data_output copy");
  a_ctl_route: assert property (@(posedge clock) disable iff (!arst_n)
    jmp_s |-> codec_ctl_cs_n == ext_ctl_cs_n_in && codec_ctl_clk == ext_ctl_clk_in
    && codec_ctl_mosi == ext_ctl_mosi_in)
    else $error("ctl header input route");
  a_ctl_default: assert property (@(posedge clock) disable iff (!arst_n)
    !jmp_s |-> !ext_ctl_oe_n && codec_ctl_cs_n == pc_spi_cs_n && ext_ctl_clk_out == pc_spi_clk)
    else $error("ctl header default");
  a_pc_mode: assert property (@(posedge clock) disable iff (!arst_n)
    pc_control_active == $past(pc_att_s))
    else $error("pc mode flag");
  a_mclk_codec: assert property (@(posedge clock) disable iff (!arst_n)
    (mclk_src_sel == ABR_MC_CODEC) |-> mclk_to_board == codec_mclk)
    else $error("mclk codec route");
  a_sclk_tx: assert property (@(posedge clock) disable iff (!arst_n)
    (serial_master_sel == ABR_MS_TX) |-> bit_clock_to_board == tx_bit_clock)
    else $error("sclk tx route");
  a_sclk_hdr: assert property (@(posedge clock) disable iff (!arst_n)
    (serial_master_sel == ABR_MS_HDR) |-> frame_clock_to_board == hdr_frame_clock_in)
    else $error("frame clock header route");

endmodule : abr_router

// ===== abr_router_test.sv
// testbench: latching, routing, pc control and control header scenarios
`timescale 1ns/1ps
module abr_router_test;
  import abr_pkg::*;
  logic clock, arst_n, reset_pushbutton, pc_port_connector, pc_cfg_valid, control_dir_jumper;
  logic [9:0] config_switch_bank, pc_cfg_data;
  logic pc_spi_cs_n, pc_spi_clk, pc_spi_mosi, ext_ctl_cs_n_in, ext_ctl_clk_in, ext_ctl_mosi_in;
  logic ext_ctl_cs_n_out, ext_ctl_clk_out, ext_ctl_mosi_out, ext_ctl_oe_n;
  logic codec_ctl_cs_n, codec_ctl_clk, codec_ctl_mosi;
  logic codec_mclk, rx_mclk, hdr_mclk_in, hdr_mclk_out, hdr_mclk_oe_n, mclk_to_board;
  logic codec_bit_clock, rx_bit_clock, tx_bit_clock, hdr_bit_clock_in;
  logic hdr_bit_clock_out, hdr_bit_clock_oe_n, bit_clock_to_board;
  logic codec_frame_clock, rx_frame_clock, tx_frame_clock, hdr_frame_clock_in;
  logic hdr_frame_clock_out, hdr_frame_clock_oe_n, frame_clock_to_board;
  logic codec_serial_data_output, rx_serial_data_output, hdr_serial_data_in, tx_data_header;
  logic pcm_header_serial_data_output, rx_data_header, codec_serial_data_input, tx_serial_data_input;
  logic [1:0] serial_master_sel, mclk_src_sel, codec_speed_mode;
  logic serial_data_input_src_sel, rx_coax_sel, format_sel, mclk_ratio_128, rx_data_valid, pc_control_active;
  logic [14:0] far_src;
  int fails, checks_done;
  assign {codec_mclk, rx_mclk, hdr_mclk_in, codec_bit_clock, rx_bit_clock, tx_bit_clock,
    hdr_bit_clock_in, codec_frame_clock, rx_frame_clock, tx_frame_clock, hdr_frame_clock_in,
    codec_serial_data_output, rx_serial_data_output, hdr_serial_data_in, tx_data_header} = far_src;
  wire [9:0] cfg_seen = {codec_speed_mode, mclk_ratio_128, format_sel, rx_coax_sel,
    serial_data_input_src_sel, mclk_src_sel, serial_master_sel};
  wire [3:0] bit_src = {hdr_bit_clock_in, tx_bit_clock, rx_bit_clock, codec_bit_clock};
  wire [3:0] frm_src = {hdr_frame_clock_in, tx_frame_clock, rx_frame_clock, codec_frame_clock};
  wire [3:0] mck_src = {hdr_mclk_in, hdr_mclk_in, codec_mclk, rx_mclk};
  wire [2:0] codec_ctl = {codec_ctl_cs_n, codec_ctl_clk, codec_ctl_mosi};
  abr_far_model u_abr_far_model (.clock(clock), .arst_n(arst_n), .far_src(far_src));
  abr_router u_abr_router (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // button held long enough for the synchroniser, then released
  task automatic press(input logic [9:0] c);
    @(posedge clock);
    config_switch_bank <= c;
    repeat (2) @(posedge clock);
    reset_pushbutton <= 1'b1;
    repeat (4) @(posedge clock);
    reset_pushbutton <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : press
  task automatic pc_load(input logic [9:0] d);
    @(posedge clock);
    pc_cfg_data <= d;
    pc_cfg_valid <= 1'b1;
    repeat (4) @(posedge clock);
    pc_cfg_valid <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : pc_load
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_latch();
    @(negedge clock);
    chk(cfg_seen, ABR_CFG_RESET);
    chk({hdr_mclk_oe_n, hdr_bit_clock_oe_n, hdr_frame_clock_oe_n}, 10'h0);
    @(posedge clock);
    config_switch_bank <= 10'h2b5;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk(cfg_seen, ABR_CFG_RESET);
    press(10'h2b5);
    chk(cfg_seen, 10'h2b5);
  endtask : t_latch
  task automatic t_route();
    logic [9:0] c;
    for (int i = 0; i < 16; i++) begin
      c = {~i[1:0], i[3:0], i[3:0]};
      press(c);
      chk(cfg_seen, c);
      chk(rx_data_valid, c[3:2] == 2'h0);
      chk(hdr_mclk_oe_n, c[3]);
      chk(hdr_bit_clock_oe_n, c[1:0] == 2'h3);
      chk(hdr_frame_clock_oe_n, c[1:0] == 2'h3);
      repeat (6) begin
        @(negedge clock);
        chk(bit_clock_to_board, bit_src[c[1:0]]);
        chk(frame_clock_to_board, frm_src[c[1:0]]);
        chk(mclk_to_board, mck_src[c[3:2]]);
        chk(codec_serial_data_input, c[4] ? hdr_serial_data_in : rx_serial_data_output);
        chk(pcm_header_serial_data_output, codec_serial_data_output);
        chk(rx_data_header, rx_serial_data_output);
        chk(tx_serial_data_input, codec_serial_data_output);
        if (c[1:0] != 2'h3) chk(hdr_bit_clock_out, bit_src[c[1:0]]);
        if (c[1:0] != 2'h3) chk(hdr_frame_clock_out, frm_src[c[1:0]]);
        if (!c[3]) chk(hdr_mclk_out, mck_src[c[3:2]]);
      end
    end
  endtask : t_route
  task automatic t_pc();
    @(posedge clock);
    pc_port_connector <= 1'b1;
    press(10'h0ab);
    chk(pc_control_active, 1'b1);
    chk(cfg_seen, 10'h0ff);
    pc_load(10'h2d6);
    chk(cfg_seen, 10'h2d6);
    repeat (6) begin
      @(negedge clock);
      chk(tx_serial_data_input, tx_data_header);
    end
    pc_load(10'h1c9);
    chk(cfg_seen, 10'h1c9);
    chk(tx_serial_data_input, codec_serial_data_output);
    @(posedge clock);
    pc_port_connector <= 1'b0;
    pc_load(10'h3ff);
    chk(pc_control_active, 1'b0);
    chk(cfg_seen, 10'h1c9);
  endtask : t_pc
  task automatic t_ctl();
    @(negedge clock);
    chk(ext_ctl_oe_n, 1'b0);
    chk(codec_ctl, 3'h5);
    chk({ext_ctl_cs_n_out, ext_ctl_clk_out, ext_ctl_mosi_out}, 3'h5);
    @(posedge clock);
    control_dir_jumper <= 1'b1;
    {pc_spi_cs_n, pc_spi_clk, pc_spi_mosi} <= 3'h3;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(ext_ctl_oe_n, 1'b1);
    chk(codec_ctl, 3'h2);
    @(posedge clock);
    {ext_ctl_cs_n_in, ext_ctl_clk_in, ext_ctl_mosi_in} <= 3'h4;
    @(negedge clock);
    chk(codec_ctl, 3'h4);
  endtask : t_ctl
  initial begin
    fails = 0;
    checks_done = 0;
    arst_n = 1'b0;
    reset_pushbutton = 1'b0;
    pc_port_connector = 1'b0;
    pc_cfg_valid = 1'b0;
    control_dir_jumper = 1'b0;
    config_switch_bank = ABR_CFG_RESET;
    pc_cfg_data = 10'h000;
    {pc_spi_cs_n, pc_spi_clk, pc_spi_mosi} = 3'h5;
    {ext_ctl_cs_n_in, ext_ctl_clk_in, ext_ctl_mosi_in} = 3'h2;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_latch();
    t_route();
    t_pc();
    t_ctl();
    end_sim();
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule : abr_router_test

// ===== abr_sync.sv
// two-flop synchroniser bank for board-level inputs
`timescale 1ns/1ps
module abr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : abr_sync
